/* File: design/rx_power_device.sv */
// Receiver digital controller: identification, voltage regulation packets, end-of-transfer.
//
// Chosen here: the address map and register access over Wishbone.
`timescale 1ns/1ps
`include "rx_power_defs.svh"
module rx_power_device (
  input wire logic CLOCK,
  input wire logic RST_B,
  rx_power_if.device LINK,
  input wire logic [7:0] RECTIFIED_NODE_LEVEL,
  input wire logic RECTIFIED_NODE_VALID,
  input wire logic [31:0] TARGETS,
  input wire logic [1:0] LOAD_STEP,
  input wire logic DIE_OVER_TEMP,
  input wire logic TEMP_HOT,
  input wire logic TEMP_COLD,
  output logic REGULATOR_EN,
  output logic TEMP_BIAS_WINDOW,
  output logic IRQ,
  input wire logic WB_CYC,
  input wire logic WB_STB,
  input wire logic WB_WE,
  input wire logic [3:0] WB_ADR,
  input wire logic [3:0] WB_SEL,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK
);
  import rx_power_pkg::*;
  typedef enum {IDLE, IDENT, CONVERGE, STEADY, ENDED} state_type;
  localparam int NORMAL_CYC = `NORMAL_PERIOD_MS * `CYCLES_PER_MS;
  localparam int FAST_CYC = `FAST_PERIOD_MS * `CYCLES_PER_MS;
  localparam int BIAS_CYC = `BIAS_WINDOW_MS * `CYCLES_PER_MS;
  localparam int DEGL_CYC = `DEGLITCH_MS * `CYCLES_PER_MS;
  localparam int CYCLE_CYC = NORMAL_CYC;
  localparam int IDENT_BITS = 16;

  state_type state_q;
  logic [31:0] tick_q;
  logic [31:0] temp_cnt_q;
  logic [31:0] hot_cnt_q;
  logic [31:0] cold_cnt_q;
  logic [4:0] ident_cnt_q;
  logic fast_q;
  logic pending_q;
  byte_type reason_q;
  target_sel_type sel_q;
  logic temp_fault_q;
  logic soft_disable_q;
  logic [3:0] irq_stat_q;
  logic [3:0] irq_mask_q;
  logic [3:0] irq_set;
  byte_type target;
  byte_type err;
  logic disable_req;
  logic overshoot;
  logic converged;
  logic fault;
  logic access;
  logic wr_commit;

  // Signed difference between measured level and selected target.
  function automatic byte_type diff(input byte_type a, input byte_type b);
    diff = a - b;
  endfunction : diff

  assign access = WB_CYC & WB_STB & ~WB_ACK;
  // Writes land at the edge where the master samples the acknowledge, not before it.
  assign wr_commit = WB_CYC & WB_STB & WB_WE & WB_ACK & WB_SEL[0];
  assign target = TARGETS[sel_q*8 +: 8];
  assign err = diff(RECTIFIED_NODE_LEVEL, target);
  assign converged = RECTIFIED_NODE_VALID && (err == 8'h00 || err == 8'hff || err == 8'h01);
  assign overshoot = RECTIFIED_NODE_VALID && $signed(err) > $signed(`OVERSHOOT_MARGIN);
  // The pins have pulldowns, so a floating pin reads low and only a driven high counts.
  assign disable_req = (LINK.host_disable_a & LINK.host_disable_b) | soft_disable_q;
  assign fault = DIE_OVER_TEMP | temp_fault_q | LINK.temp_ctrl_low;

  // Main transfer sequencer.
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      state_q <= IDLE;
      ident_cnt_q <= 5'h00;
      reason_q <= 8'h00;
    end else begin
      case (state_q)
        IDLE: begin
          if (LINK.tx_ping && disable_req) begin
            state_q <= ENDED;
            reason_q <= `END_CHARGE_DONE;
          end else if (LINK.tx_ping && !fault) begin
            state_q <= IDENT;
            ident_cnt_q <= 5'h00;
          end
        end
        // Faults and disables are honoured while identifying too, so power never starts late.
        IDENT, CONVERGE, STEADY: begin
          if (state_q == IDENT) begin
            ident_cnt_q <= ident_cnt_q + 5'h01;
            if (ident_cnt_q == 5'(IDENT_BITS - 1)) state_q <= CONVERGE;
          end else if (converged && sel_q == 2'h0) begin
            state_q <= STEADY;
          end
          if (DIE_OVER_TEMP) begin
            state_q <= ENDED;
            reason_q <= `END_INTERNAL_FAULT;
          end else if (LINK.temp_ctrl_low || temp_fault_q) begin
            state_q <= ENDED;
            reason_q <= `END_OVER_TEMP;
          end else if (disable_req) begin
            state_q <= ENDED;
            reason_q <= `END_CHARGE_DONE;
          end
        end
        ENDED: begin
          if (!disable_req && !fault) state_q <= IDLE;
        end
        default: state_q <= IDLE;
      endcase
    end
  end

  // Regulation target choice follows the host load-step hint only while delivering power.
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) sel_q <= 2'h0;
    else if (state_q == STEADY) sel_q <= LOAD_STEP;
    else sel_q <= 2'h0;
  end

  // Packet interval timer; fast mode is set by an overshoot and kept until the level converges.
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      tick_q <= 32'h0;
      fast_q <= 1'b0;
    end else begin
      if (overshoot) fast_q <= 1'b1;
      else if (converged) fast_q <= 1'b0;
      // An overshoot cuts a long wait short, so the faster pace takes hold at once.
      if (state_q != STEADY || tick_q == 32'h0 || (overshoot && tick_q > 32'(FAST_CYC - 1))) begin
        tick_q <= (fast_q || overshoot) ? 32'(FAST_CYC - 1) : 32'(NORMAL_CYC - 1);
      end else begin
        tick_q <= tick_q - 32'h1;
      end
    end
  end

  // Packet emission: identification, errors during convergence, periodic errors, end packets.
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      LINK.pkt_valid <= 1'b0;
      LINK.pkt_header <= 8'h00;
      LINK.pkt_payload <= 8'h00;
      pending_q <= 1'b0;
    end else begin
      LINK.pkt_valid <= 1'b0;
      if (state_q == ENDED && (!pending_q || LINK.tx_ping)) begin
        LINK.pkt_valid <= 1'b1;
        LINK.pkt_header <= `HDR_END;
        LINK.pkt_payload <= reason_q;
        pending_q <= 1'b1;
      end else if (state_q != ENDED) begin
        pending_q <= 1'b0;
        if (state_q == IDENT && ident_cnt_q == 5'(IDENT_BITS - 1)) begin
          LINK.pkt_valid <= 1'b1;
          LINK.pkt_header <= `HDR_IDENT;
          LINK.pkt_payload <= 8'h00;
        end else if ((state_q == CONVERGE && RECTIFIED_NODE_VALID && !converged) ||
                     (state_q == STEADY && tick_q == 32'h0)) begin
          LINK.pkt_valid <= 1'b1;
          LINK.pkt_header <= `HDR_ERROR;
          LINK.pkt_payload <= err;
        end
      end
    end
  end

  // Load modulation toggles while identifying and rests open otherwise.
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) LINK.load_mod_switch <= 1'b0;
    else LINK.load_mod_switch <= (state_q == IDENT) ? ~LINK.load_mod_switch : 1'b0;
  end

  // Regulator and indicator come straight from flops.
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      REGULATOR_EN <= 1'b0;
      LINK.transfer_active_n <= 1'b1;
    end else begin
      REGULATOR_EN <= (state_q == STEADY) && !DIE_OVER_TEMP;
      LINK.transfer_active_n <= !(state_q == CONVERGE || state_q == STEADY);
    end
  end

  // Sensor bias window and comparator deglitch; a short glitch never reaches the fault flag.
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      temp_cnt_q <= 32'h0;
      hot_cnt_q <= 32'h0;
      cold_cnt_q <= 32'h0;
      temp_fault_q <= 1'b0;
      TEMP_BIAS_WINDOW <= 1'b0;
    end else begin
      temp_cnt_q <= (temp_cnt_q == 32'(CYCLE_CYC - 1)) ? 32'h0 : temp_cnt_q + 32'h1;
      TEMP_BIAS_WINDOW <= temp_cnt_q < 32'(BIAS_CYC);
      hot_cnt_q <= (TEMP_BIAS_WINDOW && TEMP_HOT) ? hot_cnt_q + 32'h1 : 32'h0;
      cold_cnt_q <= (TEMP_BIAS_WINDOW && TEMP_COLD) ? cold_cnt_q + 32'h1 : 32'h0;
      if (hot_cnt_q >= 32'(DEGL_CYC) || cold_cnt_q >= 32'(DEGL_CYC)) temp_fault_q <= 1'b1;
      else if (TEMP_BIAS_WINDOW && !TEMP_HOT && !TEMP_COLD) temp_fault_q <= 1'b0;
    end
  end

  // Interrupt events: end packet, steady reached, fast mode entered, temperature fault.
  assign irq_set = {temp_fault_q & ~IRQ, overshoot & ~fast_q,
                    converged & (state_q == CONVERGE), LINK.pkt_valid & (LINK.pkt_header == `HDR_END)};

  // Wishbone slave with one-cycle ack; set wins over write-one-to-clear.
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      WB_ACK <= 1'b0;
      WB_DAT_O <= 32'h0;
      irq_stat_q <= 4'h0;
      irq_mask_q <= 4'h0;
      soft_disable_q <= 1'b0;
      IRQ <= 1'b0;
    end else begin
      WB_ACK <= access;
      irq_stat_q <= (irq_stat_q & ~((wr_commit && WB_ADR == `REG_IRQ) ?
                    WB_DAT_I[3:0] : 4'h0)) | irq_set;
      if (wr_commit) begin
        if (WB_ADR == `REG_CTRL) soft_disable_q <= WB_DAT_I[0];
        if (WB_ADR == `REG_MASK) irq_mask_q <= WB_DAT_I[3:0];
      end
      case (WB_ADR)
        `REG_CTRL: WB_DAT_O <= {31'h0, soft_disable_q};
        `REG_STATUS: WB_DAT_O <= {24'h0, fast_q, sel_q, REGULATOR_EN, temp_fault_q,
                                  3'(state_q)};
        `REG_IRQ: WB_DAT_O <= {28'h0, irq_stat_q};
        `REG_MASK: WB_DAT_O <= {28'h0, irq_mask_q};
        default: WB_DAT_O <= 32'h0;
      endcase
      IRQ <= |(irq_stat_q & ~irq_mask_q); // A set mask bit hides its status bit.
    end
  end
endmodule : rx_power_device

/* File: design/rx_power_defs.svh */
// Constants shared by the receiver controller and its host end.
`ifndef RX_POWER_DEFS_SVH
`define RX_POWER_DEFS_SVH
`define CLK_MHZ 100
`define NORMAL_PERIOD_MS 250
`define FAST_PERIOD_MS 32
`define BIAS_WINDOW_MS 24
`define DEGLITCH_MS 10
`define CYCLES_PER_MS (1000 * `CLK_MHZ)
`define END_CHARGE_DONE 8'h01
`define END_INTERNAL_FAULT 8'h02
`define END_OVER_TEMP 8'h03
`define HDR_IDENT 8'h71
`define HDR_ERROR 8'h03
`define HDR_END 8'h02
`define OVERSHOOT_MARGIN 8'h20
`define REG_CTRL 4'h0
`define REG_STATUS 4'h4
`define REG_IRQ 4'h8
`define REG_MASK 4'hc
`endif

/* File: design/rx_power_pkg.sv */
// Types shared by the receiver controller and its host end.
package rx_power_pkg;
  typedef logic [7:0] byte_type;
  typedef logic [1:0] target_sel_type;
endpackage : rx_power_pkg

/* File: design/rx_power_if.sv */
// Link between the receiver controller and the host/transmitter side.
`timescale 1ns/1ps
interface rx_power_if;
  logic host_disable_a;
  logic host_disable_b;
  logic temp_ctrl_out;
  logic temp_ctrl_oe_n;
  logic tx_ping;
  logic pkt_valid;
  logic [7:0] pkt_header;
  logic [7:0] pkt_payload;
  logic load_mod_switch;
  logic transfer_active_n;
  // Host pulls the control pin to ground when enable is low; otherwise it floats high.
  wire temp_ctrl_low = ~temp_ctrl_oe_n & ~temp_ctrl_out;
  modport device (input host_disable_a, host_disable_b, temp_ctrl_low, tx_ping,
    output pkt_valid, pkt_header, pkt_payload, load_mod_switch, transfer_active_n);
  modport host (output host_disable_a, host_disable_b, temp_ctrl_out, temp_ctrl_oe_n,
    tx_ping, input pkt_valid, pkt_header, pkt_payload, transfer_active_n);
endinterface : rx_power_if

/* File: design/rx_power_host.sv */
// Host and transmitter end: drives disable pins, control pin and pings.
`timescale 1ns/1ps
`include "rx_power_defs.svh"
module rx_power_host (
  input wire logic CLOCK,
  input wire logic RST_B,
  rx_power_if.host LINK,
  input wire logic DISABLE_REQ,
  input wire logic TERMINATE_REQ,
  input wire logic PING_REQ,
  output logic POWER_ON,
  output logic [7:0] LAST_REASON,
  output logic TRANSFERRING
);
  import rx_power_pkg::*;
  // Disable pins and control pin; the control pin floats except to terminate.
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      LINK.host_disable_a <= 1'b0;
      LINK.host_disable_b <= 1'b0;
      LINK.temp_ctrl_out <= 1'b0;
      LINK.temp_ctrl_oe_n <= 1'b1;
      LINK.tx_ping <= 1'b0;
    end else begin
      LINK.host_disable_a <= DISABLE_REQ;
      LINK.host_disable_b <= DISABLE_REQ;
      LINK.temp_ctrl_out <= 1'b0;
      LINK.temp_ctrl_oe_n <= ~TERMINATE_REQ;
      LINK.tx_ping <= PING_REQ & ~POWER_ON;
    end
  end
  // Transmitter power state: off on any end packet, on when the receiver identifies.
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      POWER_ON <= 1'b0;
      LAST_REASON <= 8'h00;
      TRANSFERRING <= 1'b0;
    end else begin
      TRANSFERRING <= ~LINK.transfer_active_n;
      if (LINK.pkt_valid && LINK.pkt_header == `HDR_END) begin
        POWER_ON <= 1'b0;
        LAST_REASON <= LINK.pkt_payload;
      end else if (LINK.pkt_valid && LINK.pkt_header == `HDR_IDENT) begin
        POWER_ON <= 1'b1;
      end
    end
  end
endmodule : rx_power_host

/* File: bench/rx_power_chk.sv */
// Link checker for the receiver controller and its host end.
`timescale 1ns/1ps
`include "rx_power_defs.svh"
module rx_power_chk (
  input wire logic CLOCK,
  input wire logic RST_B,
  input wire logic host_disable_a,
  input wire logic host_disable_b,
  input wire logic temp_ctrl_low,
  input wire logic tx_ping,
  input wire logic pkt_valid,
  input wire logic [7:0] pkt_header,
  input wire logic [7:0] pkt_payload,
  input wire logic transfer_active_n
);
  // One clock domain; reset silences every check.
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RST_B);
  a_end_on_disable:
    assert property (pkt_valid && pkt_header == `HDR_END && host_disable_a && host_disable_b
      |-> pkt_payload == `END_CHARGE_DONE) else $error("disable end packet has wrong code");
  a_ping_resends_end:
    assert property (tx_ping && host_disable_a && host_disable_b |-> ##[1:2] (pkt_valid
      && pkt_header == `HDR_END && pkt_payload == `END_CHARGE_DONE))
      else $error("ping while disabled got no end packet");
  a_ctrl_pin_code:
    assert property (pkt_valid && pkt_header == `HDR_END && temp_ctrl_low && !host_disable_a
      |-> pkt_payload == `END_OVER_TEMP) else $error("grounded control pin wrong code");
  a_end_single_pulse:
    assert property (pkt_valid && pkt_header == `HDR_END && !tx_ping |=> !pkt_valid)
      else $error("end packet repeated without a ping");
  a_ind_off_end:
    assert property (pkt_valid && pkt_header == `HDR_END |-> ##[0:2] transfer_active_n)
      else $error("indicator still on after end packet");
  a_ping_identifies:
    assert property (tx_ping && !host_disable_a && !host_disable_b && !temp_ctrl_low
      && transfer_active_n |-> ##[1:60] (pkt_valid && pkt_header == `HDR_IDENT))
      else $error("ping while enabled gave no identification");
  a_disable_stops:
    assert property ((host_disable_a && host_disable_b) [*4] |-> transfer_active_n)
      else $error("transfer goes on while disabled");
  a_ctrl_stops:
    assert property (temp_ctrl_low [*4] |-> transfer_active_n)
      else $error("transfer goes on with control pin grounded");
endmodule : rx_power_chk

/* File: bench/wireless_rx_power_control_bench.sv */
// Self-checking bench joining the receiver controller to its host end.
`timescale 1ns/1ps
`include "rx_power_defs.svh"
module wireless_rx_power_control_bench;
  import rx_power_pkg::*;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic rectified_node_valid = 1'b0, die_hot = 1'b0, dis_req = 1'b0, term_req = 1'b0, ping_req = 1'b0;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [1:0] load_step = 2'h0;
  logic [31:0] wdat = 32'h0, rdat;
  logic ack, reg_en, irq, power_on, transferring, bias_win;
  byte_type rectified_node_level = 8'h00;
  byte_type last_reason, last_hdr, last_pay;
  int num_errors = 0, n_tests = 0, pkt_n = 0, mod_n = 0;
  rx_power_if rx_power_if_inst ();
  always #5 clock = ~clock;
  // Targets are tied so that target zero sits mid-range, away from both rails.
  rx_power_device rx_power_device_inst (.CLOCK(clock), .RST_B(rst_b), .LINK(rx_power_if_inst),
    .RECTIFIED_NODE_LEVEL(rectified_node_level), .RECTIFIED_NODE_VALID(rectified_node_valid), .TARGETS(32'h40302080),
    .LOAD_STEP(load_step), .DIE_OVER_TEMP(die_hot), .TEMP_HOT(1'b0), .TEMP_COLD(1'b0),
    .REGULATOR_EN(reg_en), .TEMP_BIAS_WINDOW(bias_win), .IRQ(irq), .WB_CYC(cyc), .WB_STB(stb),
    .WB_WE(we), .WB_ADR(adr), .WB_SEL(4'hf), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK(ack));
  // Wireless-only system: no wired input path is modelled.
  rx_power_host rx_power_host_inst (.CLOCK(clock), .RST_B(rst_b), .LINK(rx_power_if_inst),
    .DISABLE_REQ(dis_req), .TERMINATE_REQ(term_req), .PING_REQ(ping_req),
    .POWER_ON(power_on), .LAST_REASON(last_reason), .TRANSFERRING(transferring));
  rx_power_chk rx_power_chk_inst (.CLOCK(clock), .RST_B(rst_b),
    .host_disable_a(rx_power_if_inst.host_disable_a),
    .host_disable_b(rx_power_if_inst.host_disable_b),
    .temp_ctrl_low(rx_power_if_inst.temp_ctrl_low), .tx_ping(rx_power_if_inst.tx_ping),
    .pkt_valid(rx_power_if_inst.pkt_valid), .pkt_header(rx_power_if_inst.pkt_header),
    .pkt_payload(rx_power_if_inst.pkt_payload),
    .transfer_active_n(rx_power_if_inst.transfer_active_n));
  // Packets are logged here so a scenario never misses a one-cycle pulse.
  always @(posedge clock) begin
    if (rx_power_if_inst.pkt_valid === 1'b1) begin
      pkt_n <= pkt_n + 1;
      last_hdr <= rx_power_if_inst.pkt_header;
      last_pay <= rx_power_if_inst.pkt_payload;
    end
    if (rx_power_if_inst.load_mod_switch === 1'b1)
      mod_n <= mod_n + 1;
  end
  task summarize();
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize
  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // Waits, bounded, for the next packet logged after entry.
  task wait_pkt(output byte_type hdr, output byte_type pay);
    int n0;
    int k;
    n0 = pkt_n;
    for (k = 0; k < 300 && pkt_n == n0; k++)
      @(posedge clock);
    if (k == 300) begin
      chk("packet timeout", 0, 1);
      summarize();
    end
    hdr = last_hdr;
    pay = last_pay;
  endtask : wait_pkt
  // Classic single Wishbone cycle; read data is taken at the acknowledging edge.
  task wb(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    int k;
    @(posedge clock);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    for (k = 0; k < 50; k++) begin
      @(posedge clock);
      if (ack === 1'b1)
        break;
    end
    if (k == 50) begin
      chk("bus timeout", 0, 1);
      summarize();
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  task pulse_ping();
    @(posedge clock);
    ping_req <= 1'b1;
    @(posedge clock);
    ping_req <= 1'b0;
  endtask : pulse_ping
  task set_rectified_node(input byte_type lvl);
    @(posedge clock);
    rectified_node_level <= lvl;
    rectified_node_valid <= 1'b1;
    @(posedge clock);
    rectified_node_valid <= 1'b0;
  endtask : set_rectified_node
  // Ping, identify, one error packet, then convergence at the edge of the band.
  task power_up();
    byte_type h, p;
    int m0;
    m0 = mod_n;
    pulse_ping();
    wait_pkt(h, p);
    chk("ident header", h, `HDR_IDENT);
    chk("switch toggled", mod_n != m0, 1'b1);
    repeat (20) @(posedge clock);
    set_rectified_node(8'h50);
    wait_pkt(h, p);
    chk("error header", h, `HDR_ERROR);
    chk("error value", p, 8'hd0);
    chk("regulator held", reg_en, 1'b0);
    set_rectified_node(8'h81);
    repeat (3) @(posedge clock);
    chk("regulator on", reg_en, 1'b1);
    chk("indicator on", rx_power_if_inst.transfer_active_n, 1'b0);
    chk("host sees transfer", transferring, 1'b1);
    chk("tx power on", power_on, 1'b1);
    chk("bias window", bias_win, 1'b1);
  endtask : power_up
  // Overshoot speeds up feedback; its event is masked, cleared and then the pace returns.
  task steady_checks();
    logic [31:0] q;
    wb(1'b0, `REG_STATUS, 32'h0, q);
    chk("steady status", q, 32'h13);
    load_step <= 2'h1;
    repeat (2) @(posedge clock);
    wb(1'b0, `REG_STATUS, 32'h0, q);
    chk("target select", q, 32'h33);
    load_step <= 2'h0;
    repeat (2) @(posedge clock);
    set_rectified_node(8'ha1);
    repeat (3) @(posedge clock);
    wb(1'b0, `REG_STATUS, 32'h0, q);
    chk("fast status", q, 32'h93);
    chk("irq raised", irq, 1'b1);
    wb(1'b1, `REG_MASK, 32'hf, q);
    repeat (2) @(posedge clock);
    chk("irq masked", irq, 1'b0);
    wb(1'b0, `REG_IRQ, 32'h0, q);
    chk("irq bits", q, 32'h6);
    wb(1'b1, `REG_IRQ, 32'h6, q);
    wb(1'b0, `REG_IRQ, 32'h0, q);
    chk("irq cleared", q, 32'h0);
    wb(1'b1, `REG_MASK, 32'h0, q);
    set_rectified_node(8'h80);
    repeat (3) @(posedge clock);
    wb(1'b0, `REG_STATUS, 32'h0, q);
    chk("normal status", q, 32'h13);
    wb(1'b0, 4'h2, 32'h0, q);
    chk("unmapped read", q, 32'h0);
  endtask : steady_checks
  // Ends transfer by host disable, grounded control pin or die heat, then releases it.
  task end_case(input int i);
    byte_type h, p, code;
    code = (i == 0) ? `END_CHARGE_DONE : (i == 1) ? `END_OVER_TEMP : `END_INTERNAL_FAULT;
    @(posedge clock);
    dis_req <= (i == 0);
    term_req <= (i == 1);
    die_hot <= (i == 2);
    wait_pkt(h, p);
    chk("end header", h, `HDR_END);
    chk("end reason", p, code);
    repeat (4) @(posedge clock);
    chk("regulator off", reg_en, 1'b0);
    chk("indicator off", rx_power_if_inst.transfer_active_n, 1'b1);
    chk("host reason", last_reason, code);
    chk("tx power off", power_on, 1'b0);
    if (i == 0) begin
      pulse_ping();
      wait_pkt(h, p);
      chk("resent reason", p, `END_CHARGE_DONE);
    end
    @(posedge clock);
    dis_req <= 1'b0;
    term_req <= 1'b0;
    die_hot <= 1'b0;
    repeat (5) @(posedge clock);
  endtask : end_case
  // Each pass restarts transfer, so a release is always followed by a fresh ping.
  initial begin
    logic [31:0] q;
    byte_type h, p;
    repeat (3) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    chk("reset indicator", rx_power_if_inst.transfer_active_n, 1'b1);
    chk("reset regulator", reg_en, 1'b0);
    for (int i = 0; i < 3; i++) begin
      power_up();
      if (i == 0)
        steady_checks();
      end_case(i);
    end
    // Software disable ends transfer like the pins; a mid-run reset must then clear it.
    power_up();
    wb(1'b1, `REG_CTRL, 32'h1, q);
    wait_pkt(h, p);
    chk("soft end reason", p, `END_CHARGE_DONE);
    wb(1'b0, `REG_CTRL, 32'h0, q);
    chk("ctrl set", q, 32'h1);
    rst_b <= 1'b0;
    repeat (3) @(posedge clock);
    chk("mid reset indicator", rx_power_if_inst.transfer_active_n, 1'b1);
    rst_b <= 1'b1;
    @(posedge clock);
    wb(1'b0, `REG_CTRL, 32'h0, q);
    chk("ctrl after reset", q, 32'h0);
    power_up();
    summarize();
  end
endmodule : wireless_rx_power_control_bench
